// ---- hdl/gtc_pkg.sv ----
// Package for the general timer control block: register map, field layout, constants.
// Assumes a single 125 MHz clock domain and an AXI4-Lite register bus.
package gtc_pkg;
    localparam logic [11:0] CTL0_OFFSET    = 12'h000;
    localparam logic [11:0] RELOAD_OFFSET  = 12'h004;
    localparam logic [11:0] COUNT_OFFSET   = 12'h008;
    localparam logic [11:0] CMP_OFFSET     = 12'h00c;
    localparam logic [11:0] SWEV_OFFSET    = 12'h010;
    localparam logic [11:0] IRQ_STAT_OFFSET = 12'h014;
    localparam logic [11:0] IRQ_EN_OFFSET  = 12'h018;
    localparam logic [11:0] IRQ_CLR_OFFSET = 12'h01c;
    localparam logic [11:0] INPUT_OFFSET   = 12'h020;

    localparam int DIV_LSB    = 8;
    localparam int RELOAD_SHADOW_ENABLE_BIT   = 7;
    localparam int ALIGN_LSB  = 5;
    localparam int DIR_BIT    = 4;
    localparam int ONESHOT_BIT = 3;
    localparam int UPS_BIT    = 2;
    localparam int UPDATE_INHIBIT_BIT  = 1;
    localparam int RUN_BIT    = 0;
    localparam int CTL0_W     = 10;

    localparam logic [9:0]  CTL0_RESET   = 10'h000;
    localparam logic [15:0] RELOAD_RESET = 16'hffff;
    localparam logic [15:0] CMP_RESET    = 16'h0000;
    localparam logic [1:0]  IRQ_RESET    = 2'h0;

    localparam int IRQ_UPDATE = 0;
    localparam int IRQ_CMP    = 1;

    localparam logic [1:0] ALIGN_EDGE = 2'h0;
    localparam logic [1:0] ALIGN_DOWN = 2'h1;
    localparam logic [1:0] ALIGN_UP   = 2'h2;
    localparam logic [1:0] ALIGN_BOTH = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        GTC_DIR_UP   = 2'b01,
        GTC_DIR_DOWN = 2'b10
    } gtc_dir_e;

    // Sample clock period in kernel cycles for a divider code; reserved code gives 1
    function automatic logic [2:0] gtc_div_period(input logic [1:0] code);
        unique case (code)
            2'h1:    gtc_div_period = 3'h2;
            2'h2:    gtc_div_period = 3'h4;
            default: gtc_div_period = 3'h1;
        endcase
    endfunction
endpackage

// ---- hdl/gtc_sample_div.sv ----
// Sample clock enable divider for filter and dead-time logic.
// Assumes a divider code from the control register on the same clock.
`timescale 1ns/1ps
module gtc_sample_div
    import gtc_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       ce,
    input  wire logic [1:0] div_code,
    output logic            sample_tick
);
    logic [2:0] cnt_q;
    logic [2:0] period;

    assign period = gtc_div_period(div_code);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q       <= 3'h0;
            sample_tick <= 1'b0;
        end else if (ce) begin
            if (cnt_q >= period - 3'h1) begin
                cnt_q       <= 3'h0;
                sample_tick <= 1'b1;
            end else begin
                cnt_q       <= cnt_q + 3'h1;
                sample_tick <= 1'b0;
            end
        end
    end

    a_tick_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && div_code == 2'h2 && $stable(div_code) && sample_tick)
        |=> !sample_tick) else $error("sample tick too frequent");
endmodule

// ---- hdl/gtc_event_flags.sv ----
// Sticky interrupt status with enable and write-one-to-clear.
// Assumes event pulses and clear strobes on the same clock.
`timescale 1ns/1ps
module gtc_event_flags
    import gtc_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       ce,
    input  wire logic [1:0] set_pulse,
    input  wire logic [1:0] clr_mask,
    input  wire logic       en_we,
    input  wire logic [1:0] en_wdata,
    output logic [1:0]      status_q,
    output logic [1:0]      enable_q,
    output logic            irq_q
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= IRQ_RESET;
        end else if (ce) begin
            // Set wins over a clear in the same cycle
            status_q <= (status_q & ~clr_mask) | set_pulse;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_q <= IRQ_RESET;
        end else if (ce && en_we) begin
            enable_q <= en_wdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= |(((status_q & ~clr_mask) | set_pulse) & (en_we ? en_wdata : enable_q));
        end
    end
endmodule

// ---- hdl/gtc_timer.sv ----
// Timer counter with its first control register, reload, compare and event flags.
// Assumes AXI4-Lite master on aclk; restart and mode inputs arrive as async pins.
`timescale 1ns/1ps
// Notes on behaviour
// - Divider code 00, 01, 10 gives sample tick every 1, 2, 4 cycles.
// - Reload shadow enabled buffers reload value until update; disabled writes act at once.
// - Alignment 00 counts edge-aligned in the direction bit's sense.
// - Alignment 01 center-aligned, compare flag only while counting down.
// - Alignment 10 center-aligned, compare flag only while counting up.
// - Alignment 11 center-aligned, compare flag in both directions.
// - Direction 0 up, 1 down; read-only in center or encoder operation.
// - One-shot mode stops the counter at the next update event.
// - Update source 0: software request, overflow/underflow, restart raise update flag.
// - Update source 1: only overflow or underflow raises update flag.
// - Update inhibit 0: each update event loads preloaded values into shadows.
// - Update inhibit 1: request or restart reinitializes counter without update event.
// - Counter counts only while run bit is set; software sets it itself.
// - Control register accepts half-word and word writes via byte strobes.
module gtc_timer
    import gtc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        restart_pin,
    input  wire logic        encoder_mode_pin,
    output logic             sample_tick_q,
    output logic             update_pulse_q,
    output logic             compare_pulse_q,
    output logic             irq_q
);
    logic [9:0]  ctl_q;
    logic [15:0] reload_pre_q;
    logic [15:0] reload_act_q;
    logic [15:0] cmp_pre_q;
    logic [15:0] cmp_act_q;
    logic [15:0] count_q;
    gtc_dir_e    phase_q;
    logic [1:0]  restart_s_q;
    logic [1:0]  enc_s_q;
    logic        restart_prev_q;
    logic        swreq_q;
    logic [11:0] awaddr_q;
    logic        aw_have_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        w_have_q;
    logic        sample_tick;
    logic [1:0]  stat;
    logic [1:0]  irq_en;
    logic        irq_w;

    logic        wr_go;
    logic        restart_evt;
    logic        center;
    logic        count_up;
    logic        at_end;
    logic        turn;
    logic        wrap_evt;
    logic        reinit;
    logic        upd_evt;
    logic        upd_flag;
    logic        cmp_match;
    logic        cmp_flag;
    logic [15:0] ctl_lo_merged;
    logic [1:0]  irq_clr;
    logic        irq_en_we;

    assign wr_go       = aw_have_q && w_have_q && !s_axi_bvalid;
    assign restart_evt = restart_s_q[1] && !restart_prev_q;
    assign center      = ctl_q[ALIGN_LSB +: 2] != ALIGN_EDGE;
    assign count_up    = (phase_q == GTC_DIR_UP);
    assign at_end      = count_up ? (count_q >= reload_act_q) : (count_q == 16'h0000);
    // Center turnarounds stand for overflow and underflow, or center mode never updates
    assign turn        = count_up ? (count_q >= reload_act_q - 16'h0001) : (count_q == 16'h0001);
    assign wrap_evt    = ctl_q[RUN_BIT] && (center ? turn : at_end);
    assign reinit      = swreq_q || restart_evt;
    assign upd_evt     = wrap_evt || (reinit && !ctl_q[UPDATE_INHIBIT_BIT]);
    assign upd_flag    = wrap_evt || (upd_evt && !ctl_q[UPS_BIT]);
    assign cmp_match   = ctl_q[RUN_BIT] && count_q == cmp_act_q;

    // Compare flag qualified by alignment and phase
    always_comb begin
        unique case (ctl_q[ALIGN_LSB +: 2])
            ALIGN_DOWN: cmp_flag = cmp_match && !count_up;
            ALIGN_UP:   cmp_flag = cmp_match && count_up;
            ALIGN_BOTH: cmp_flag = cmp_match;
            default:    cmp_flag = cmp_match;
        endcase
    end

    // Half-word or word writes merge lane by lane
    always_comb begin
        ctl_lo_merged = {6'h00, ctl_q};
        if (wstrb_q[0]) begin
            ctl_lo_merged[7:0] = wdata_q[7:0];
        end
        if (wstrb_q[1]) begin
            ctl_lo_merged[15:8] = {6'h00, wdata_q[9:8]};
        end
        if (center || enc_s_q[1]) begin
            ctl_lo_merged[DIR_BIT] = ctl_q[DIR_BIT];
        end
    end

    assign irq_clr   = (wr_go && awaddr_q == IRQ_CLR_OFFSET) ? wdata_q[1:0] : 2'h0;
    assign irq_en_we = wr_go && awaddr_q == IRQ_EN_OFFSET;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            restart_s_q    <= 2'h0;
            enc_s_q        <= 2'h0;
            restart_prev_q <= 1'b0;
        end else if (ce) begin
            restart_s_q    <= {restart_s_q[0], restart_pin};
            enc_s_q        <= {enc_s_q[0], encoder_mode_pin};
            restart_prev_q <= restart_s_q[1];
        end
    end

    // AXI write channel capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 12'h000;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bresp <= RESP_OKAY;
        end else if (ce && wr_go) begin
            unique case (awaddr_q)
                CTL0_OFFSET, RELOAD_OFFSET, CMP_OFFSET, SWEV_OFFSET,
                IRQ_EN_OFFSET, IRQ_CLR_OFFSET: s_axi_bresp <= RESP_OKAY;
                default:                       s_axi_bresp <= RESP_SLVERR;
            endcase
        end
    end

    // Control register; one-shot clears run at the update event
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_q <= CTL0_RESET;
        end else if (ce) begin
            if (wr_go && awaddr_q == CTL0_OFFSET) begin
                ctl_q <= ctl_lo_merged[CTL0_W-1:0];
            end else if (upd_evt && ctl_q[ONESHOT_BIT]) begin
                ctl_q[RUN_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swreq_q <= 1'b0;
        end else if (ce) begin
            swreq_q <= wr_go && awaddr_q == SWEV_OFFSET && wdata_q[0];
        end
    end

    // Preload and shadow values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reload_pre_q <= RELOAD_RESET;
            reload_act_q <= RELOAD_RESET;
            cmp_pre_q    <= CMP_RESET;
            cmp_act_q    <= CMP_RESET;
        end else if (ce) begin
            if (wr_go && awaddr_q == RELOAD_OFFSET) begin
                reload_pre_q <= wdata_q[15:0];
                if (!ctl_q[RELOAD_SHADOW_ENABLE_BIT]) begin
                    reload_act_q <= wdata_q[15:0];
                end
            end else if (upd_evt) begin
                reload_act_q <= reload_pre_q;
            end
            if (wr_go && awaddr_q == CMP_OFFSET) begin
                cmp_pre_q <= wdata_q[15:0];
            end else if (upd_evt) begin
                cmp_act_q <= cmp_pre_q;
            end
        end
    end

    // Counter and direction phase
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= 16'h0000;
            phase_q <= GTC_DIR_UP;
        end else if (ce) begin
            if (!center) begin
                phase_q <= ctl_q[DIR_BIT] ? GTC_DIR_DOWN : GTC_DIR_UP;
            end
            if (reinit) begin
                count_q <= count_up ? 16'h0000 : reload_act_q;
            end else if (ctl_q[RUN_BIT]) begin
                if (center) begin
                    if (turn) begin
                        phase_q <= count_up ? GTC_DIR_DOWN : GTC_DIR_UP;
                    end
                    count_q <= count_up ? count_q + 16'h0001 : count_q - 16'h0001;
                end else if (at_end) begin
                    count_q <= count_up ? 16'h0000 : reload_act_q;
                end else begin
                    count_q <= count_up ? count_q + 16'h0001 : count_q - 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            update_pulse_q  <= 1'b0;
            compare_pulse_q <= 1'b0;
        end else if (ce) begin
            update_pulse_q  <= upd_flag;
            compare_pulse_q <= cmp_flag;
        end
    end

    // Read channel: one-cycle answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                unique case ({s_axi_araddr[11:2], 2'b00})
                    CTL0_OFFSET:     s_axi_rdata <= {22'h000000, ctl_q};
                    RELOAD_OFFSET:   s_axi_rdata <= {16'h0000, reload_pre_q};
                    COUNT_OFFSET:    s_axi_rdata <= {16'h0000, count_q};
                    CMP_OFFSET:      s_axi_rdata <= {16'h0000, cmp_pre_q};
                    IRQ_STAT_OFFSET: s_axi_rdata <= {30'h00000000, stat};
                    IRQ_EN_OFFSET:   s_axi_rdata <= {30'h00000000, irq_en};
                    INPUT_OFFSET:    s_axi_rdata <= {30'h00000000, enc_s_q[1], count_up};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    assign s_axi_arready = !s_axi_rvalid;
    assign irq_q = irq_w;

    gtc_sample_div u_div (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .ce          (ce),
        .div_code    (ctl_q[DIV_LSB +: 2]),
        .sample_tick (sample_tick)
    );

    assign sample_tick_q = sample_tick;

    gtc_event_flags u_flags (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .set_pulse ({cmp_flag, upd_flag}),
        .clr_mask  (irq_clr),
        .en_we     (irq_en_we),
        .en_wdata  (wdata_q[1:0]),
        .status_q  (stat),
        .enable_q  (irq_en),
        .irq_q     (irq_w)
    );

    a_oneshot_stop: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && upd_evt && ctl_q[ONESHOT_BIT] && !(wr_go && awaddr_q == CTL0_OFFSET))
        |=> !ctl_q[RUN_BIT]) else $error("one-shot did not stop");
    a_hold_stopped: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !ctl_q[RUN_BIT] && !reinit) |=> $stable(count_q))
        else $error("counter moved while stopped");
    a_ups_filter: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && ctl_q[UPS_BIT] && !wrap_evt) |=> !update_pulse_q)
        else $error("update flag from filtered source");
    a_ups_all: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !ctl_q[UPS_BIT] && !ctl_q[UPDATE_INHIBIT_BIT] && swreq_q) |=> update_pulse_q)
        else $error("software update missed");
    a_inhibit_reinit: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && ctl_q[UPDATE_INHIBIT_BIT] && swreq_q && !wrap_evt && count_up)
        |=> count_q == 16'h0000 && !update_pulse_q)
        else $error("inhibited request misbehaved");
    a_cmp_down: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && ctl_q[ALIGN_LSB +: 2] == ALIGN_DOWN && count_up) |=> !compare_pulse_q)
        else $error("compare flag while up in down mode");
    a_cmp_up: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && ctl_q[ALIGN_LSB +: 2] == ALIGN_UP && !count_up) |=> !compare_pulse_q)
        else $error("compare flag while down in up mode");
    a_cmp_both: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && ctl_q[ALIGN_LSB +: 2] == ALIGN_BOTH && cmp_match) |=> compare_pulse_q)
        else $error("compare flag missed");
    a_dir_locked: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && center) |=> $stable(ctl_q[DIR_BIT]))
        else $error("direction changed in center mode");
    a_edge_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && !center && count_up && !ctl_q[DIR_BIT] && wrap_evt && !reinit)
        |=> count_q == 16'h0000) else $error("edge counter did not wrap");
    a_direct_reload: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && wr_go && awaddr_q == RELOAD_OFFSET && !ctl_q[RELOAD_SHADOW_ENABLE_BIT])
        |=> reload_act_q == $past(wdata_q[15:0])) else $error("reload not direct");
    a_hword_ctl: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && wr_go && awaddr_q == CTL0_OFFSET && wstrb_q == 4'h3 && !center && !enc_s_q[1])
        |=> ctl_q == $past(wdata_q[9:0])) else $error("half-word write lost");
    a_upd_shadow: assert property (@(posedge aclk) disable iff (!aresetn)
        (ce && upd_evt && !(wr_go && awaddr_q == CMP_OFFSET)) |=> cmp_act_q == $past(cmp_pre_q))
        else $error("shadow not loaded");

    c_one_shot: cover property (@(posedge aclk) ctl_q[ONESHOT_BIT] && upd_evt);
    c_center:   cover property (@(posedge aclk) center && ctl_q[RUN_BIT] && cmp_flag);
    c_restart:  cover property (@(posedge aclk) restart_evt && ctl_q[UPDATE_INHIBIT_BIT]);
    c_irq:      cover property (@(posedge aclk) irq_w);
endmodule

// ---- tb/gtc_timer_tb_top.sv ----
// Self-checking bench for the timer control block: registers, counting, events, irq.
// Assumes the block alone on one 125 MHz clock, driven over AXI4-Lite by the tasks here.
`timescale 1ns/1ps
module general_timer_control0_tb_top;
    import gtc_pkg::*;
    logic        aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        restart_pin = 1'h0, encoder_mode_pin = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp_q;
    logic        sample_tick_q, update_pulse_q, compare_pulse_q, irq_q;
    int          failures = 0, check_count = 0;
    always #4 aclk = ~aclk;
    gtc_timer uut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .restart_pin,
        .encoder_mode_pin, .sample_tick_q, .update_pulse_q, .compare_pulse_q, .irq_q);
    task automatic complete_run();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tmo(input int n, input int lim);
        if (n >= lim) begin
            failures++;
            $display("CHECK FAILED at %0t: waited %h of %h", $time, n, lim);
            complete_run();
        end
    endtask
    // Ready is looked at on the falling edge, so release happens right after the taking edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic ta, tw, tb;
        int n;
        n = 0;
        tb = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!tb) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            resp_q = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            n++;
            tmo(n, 64);
        end
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a);
        logic ta, tr;
        int n;
        n = 0;
        tr = 1'h0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (!tr) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            rd_q = s_axi_rdata;
            resp_q = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'h0;
            n++;
            tmo(n, 64);
        end
        s_axi_rready <= 1'h0;
    endtask
    task automatic wait_upd();
        int n;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
            tmo(n, 200);
        end while (update_pulse_q !== 1'h1);
    endtask
    task automatic t_regs();
        rd(CTL0_OFFSET);
        chk(rd_q, 32'h0);
        rd(RELOAD_OFFSET);
        chk(rd_q, 32'hffff);
        wr(CTL0_OFFSET, 32'h00000280, 4'h3);
        chk({30'h0, resp_q}, {30'h0, RESP_OKAY});
        rd(CTL0_OFFSET);
        chk(rd_q, 32'h280);
        wr(CTL0_OFFSET, 32'h0, 4'h1);
        rd(CTL0_OFFSET);
        chk(rd_q, 32'h200);
        rd(12'h03c);
        chk({30'h0, resp_q}, {30'h0, RESP_SLVERR});
        wr(12'h03c, 32'h0);
        chk({30'h0, resp_q}, {30'h0, RESP_SLVERR});
        $display("test regs done");
    endtask
    task automatic t_div();
        int k;
        for (int c = 0; c < 3; c++) begin
            wr(CTL0_OFFSET, 32'(c) << 8);
            k = 0;
            repeat (16) begin
                @(negedge aclk);
                if (sample_tick_q === 1'h1) k++;
            end
            chk(32'(k), 32'(16 >> c));
        end
        $display("test div done");
    endtask
    task automatic t_count();
        logic [31:0] a;
        wr(CTL0_OFFSET, 32'h0);
        wr(RELOAD_OFFSET, 32'h5);
        wr(SWEV_OFFSET, 32'h1);
        repeat (8) @(posedge aclk);
        rd(COUNT_OFFSET);
        chk(rd_q, 32'h0);
        wr(IRQ_CLR_OFFSET, 32'h3);
        wr(CTL0_OFFSET, 32'h1);
        wait_upd();
        rd(IRQ_STAT_OFFSET);
        chk(rd_q & 32'h1, 32'h1);
        chk({31'h0, irq_q}, 32'h0);
        wr(IRQ_EN_OFFSET, 32'h1);
        @(negedge aclk);
        chk({31'h0, irq_q}, 32'h1);
        wr(CTL0_OFFSET, 32'h11);
        wait_upd();
        rd(INPUT_OFFSET);
        chk(rd_q & 32'h1, 32'h0);
        wr(CTL0_OFFSET, 32'h9);
        wait_upd();
        repeat (4) @(posedge aclk);
        rd(COUNT_OFFSET);
        a = rd_q;
        repeat (8) @(posedge aclk);
        rd(COUNT_OFFSET);
        chk(rd_q, a);
        wr(CTL0_OFFSET, 32'h0);
        wr(IRQ_CLR_OFFSET, 32'h3);
        @(negedge aclk);
        chk({31'h0, irq_q}, 32'h0);
        $display("test count done");
    endtask
    task automatic t_upd();
        logic [31:0] cv [3] = '{32'h0, 32'h4, 32'h2};
        logic [31:0] ev [3] = '{32'h1, 32'h0, 32'h0};
        for (int i = 0; i < 3; i++) begin
            wr(CTL0_OFFSET, cv[i]);
            wr(IRQ_CLR_OFFSET, 32'h3);
            wr(SWEV_OFFSET, 32'h1);
            rd(IRQ_STAT_OFFSET);
            chk(rd_q & 32'h1, ev[i]);
        end
        wr(CTL0_OFFSET, 32'h0);
        wr(IRQ_CLR_OFFSET, 32'h3);
        restart_pin <= 1'h1;
        repeat (4) @(posedge aclk);
        restart_pin <= 1'h0;
        rd(IRQ_STAT_OFFSET);
        chk(rd_q & 32'h1, 32'h1);
        $display("test update source done");
    endtask
    task automatic t_dir();
        wr(CTL0_OFFSET, 32'h10);
        rd(CTL0_OFFSET);
        chk(rd_q, 32'h10);
        wr(CTL0_OFFSET, 32'h20);
        wr(CTL0_OFFSET, 32'h30);
        rd(CTL0_OFFSET);
        chk(rd_q, 32'h20);
        wr(CTL0_OFFSET, 32'h0);
        encoder_mode_pin <= 1'h1;
        repeat (4) @(posedge aclk);
        wr(CTL0_OFFSET, 32'h10);
        rd(CTL0_OFFSET);
        chk(rd_q, 32'h0);
        encoder_mode_pin <= 1'h0;
        $display("test direction done");
    endtask
    // Each mode starts from the same reinitialised count, so match counts are comparable
    task automatic t_cmp();
        int p [4];
        wr(RELOAD_OFFSET, 32'h8);
        wr(CMP_OFFSET, 32'h3);
        for (int m = 1; m < 4; m++) begin
            wr(CTL0_OFFSET, 32'h0);
            wr(SWEV_OFFSET, 32'h1);
            wr(CTL0_OFFSET, (32'(m) << 5) | 32'h1);
            p[m] = 0;
            repeat (64) begin
                @(negedge aclk);
                if (compare_pulse_q === 1'h1) p[m]++;
            end
        end
        chk(32'(p[3]), 32'(p[1] + p[2]));
        chk(32'(p[1] == 0), 32'h0);
        chk(32'(p[2] == 0), 32'h0);
        wait_upd();
        wr(CTL0_OFFSET, 32'h0);
        $display("test compare done");
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs();
        t_div();
        t_count();
        t_upd();
        t_dir();
        t_cmp();
        complete_run();
    end
endmodule
